// ### shared/lpd_map.svh
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

// ****************************************************************
// synchronised pin vector layout
// ****************************************************************
`define LPD_PIN_W 8
`define LPD_PIN_HOST 0
`define LPD_PIN_REGRST 1
`define LPD_PIN_EQDIS 2
`define LPD_PIN_THRSEL 3
`define LPD_PIN_LLOOP 4
`define LPD_PIN_RLOOP 5
`define LPD_PIN_E3 6
`define LPD_PIN_STS1 7
// reg reset pin idles high, all others low
`define LPD_PIN_RST_VAL 8'h02

// ****************************************************************
// command register defaults
// ****************************************************************
`define LPD_CMD_EQDIS_DEF 1'h0
`define LPD_CMD_LLOOP_DEF 1'h0
`define LPD_CMD_RLOOP_DEF 1'h0
`define LPD_CMD_THRSEL_DEF 1'h0
`define LPD_CMD_INV_DEF 1'h0
`define LPD_CMD_E3_DEF 1'h0
`define LPD_CMD_STS1_DEF 1'h0

// ****************************************************************
// output reset values
// ****************************************************************
`define LPD_BIT_LOW 1'h0
`define LPD_BIT_HIGH 1'h1

`endif

// ### shared/lpd_pkg.sv
package lpd_pkg;

    typedef enum logic [1:0] {
        LPD_LOOP_NONE,
        LPD_LOOP_ANALOG_LOCAL,
        LPD_LOOP_DIGITAL_LOCAL,
        LPD_LOOP_REMOTE
    } lpd_loop_t;

endpackage

// ### hdl/lpd_sync.sv
`timescale 1ns/100ps
`include "lpd_map.svh"

module lpd_sync #(
    parameter int W = `LPD_PIN_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_hold;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_hold = meta_ff;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= RST_VAL;
            hold_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign sync_out = hold_ff;

endmodule // lpd_sync

// ### hdl/lpd_top.sv
`timescale 1ns/100ps
`include "lpd_map.svh"

// Functional notes
// - host mode: reg reset low restores command defaults
// - undriven register reset input reads high
// - hardware mode, invert low: data on rising
// - hardware mode, invert high: data on falling
// - equalizer disabled while disable input high
// - host mode: eq/loop pins ignored, registers used
// - threshold applies only at DS3/STS-1 rates
// - local high, remote low: analog local loop
// - both high: digital local loop
// - remote high, local low: remote loop
// - mode select high host, low hardware

module lpd_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration pins
    input wire logic host_hardware_mode_sel,
    input wire logic cfg_reg_reset_n,
    input wire logic cfg_reg_reset_drv,
    input wire logic rx_equalizer_disable,
    input wire logic signal_loss_threshold_sel,
    input wire logic local_loop_sel,
    input wire logic remote_loop_sel,
    input wire logic rate_e3_sel,
    input wire logic rate_sts1_sel,
    // command register write port, same clock
    input wire logic cmd_wr,
    input wire logic cmd_eq_disable,
    input wire logic cmd_local_loop,
    input wire logic cmd_remote_loop,
    input wire logic cmd_loss_threshold,
    input wire logic cmd_clk_invert,
    input wire logic cmd_rate_e3,
    input wire logic cmd_rate_sts1,
    // recovered rail data, same clock
    input wire logic rx_pos_in,
    input wire logic rx_neg_in,
    // receive outputs
    output logic rx_recovered_clk_b,
    output logic rx_pos_rail_data,
    output logic rx_neg_rail_data,
    // decoded configuration
    output logic host_mode,
    output logic equalizer_enable,
    output logic loss_threshold_high,
    output logic loss_threshold_active,
    output lpd_pkg::lpd_loop_t loop_mode,
    output logic analog_local_loop,
    output logic digital_local_loop,
    output logic remote_loop
);

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    logic [`LPD_PIN_W-1:0] pin_raw;
    logic [`LPD_PIN_W-1:0] pin_s;
    logic reg_reset_level;

    // weak pull-up: an undriven pin reads high
    assign reg_reset_level = cfg_reg_reset_drv ? cfg_reg_reset_n : `LPD_BIT_HIGH;

    always_comb
    begin
        pin_raw = '0;
        pin_raw[`LPD_PIN_HOST] = host_hardware_mode_sel;
        pin_raw[`LPD_PIN_REGRST] = reg_reset_level;
        pin_raw[`LPD_PIN_EQDIS] = rx_equalizer_disable;
        pin_raw[`LPD_PIN_THRSEL] = signal_loss_threshold_sel;
        pin_raw[`LPD_PIN_LLOOP] = local_loop_sel;
        pin_raw[`LPD_PIN_RLOOP] = remote_loop_sel;
        pin_raw[`LPD_PIN_E3] = rate_e3_sel;
        pin_raw[`LPD_PIN_STS1] = rate_sts1_sel;
    end

    lpd_sync #(
        .W(`LPD_PIN_W),
        .RST_VAL(`LPD_PIN_RST_VAL)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    logic is_host;
    assign is_host = pin_s[`LPD_PIN_HOST];

    // ****************************************************************
    // command registers
    // ****************************************************************
    logic cmd_eqdis_ff, cmd_lloop_ff, cmd_rloop_ff, cmd_thrsel_ff;
    logic cmd_inv_ff, cmd_e3_ff, cmd_sts1_ff;
    logic nxt_cmd_eqdis, nxt_cmd_lloop, nxt_cmd_rloop, nxt_cmd_thrsel;
    logic nxt_cmd_inv, nxt_cmd_e3, nxt_cmd_sts1;

    always_comb
    begin
        nxt_cmd_eqdis = cmd_eqdis_ff;
        nxt_cmd_lloop = cmd_lloop_ff;
        nxt_cmd_rloop = cmd_rloop_ff;
        nxt_cmd_thrsel = cmd_thrsel_ff;
        nxt_cmd_inv = cmd_inv_ff;
        nxt_cmd_e3 = cmd_e3_ff;
        nxt_cmd_sts1 = cmd_sts1_ff;
        // reset wins over a write in the same cycle
        if (is_host && !pin_s[`LPD_PIN_REGRST])
        begin
            nxt_cmd_eqdis = `LPD_CMD_EQDIS_DEF;
            nxt_cmd_lloop = `LPD_CMD_LLOOP_DEF;
            nxt_cmd_rloop = `LPD_CMD_RLOOP_DEF;
            nxt_cmd_thrsel = `LPD_CMD_THRSEL_DEF;
            nxt_cmd_inv = `LPD_CMD_INV_DEF;
            nxt_cmd_e3 = `LPD_CMD_E3_DEF;
            nxt_cmd_sts1 = `LPD_CMD_STS1_DEF;
        end
        else if (cmd_wr)
        begin
            nxt_cmd_eqdis = cmd_eq_disable;
            nxt_cmd_lloop = cmd_local_loop;
            nxt_cmd_rloop = cmd_remote_loop;
            nxt_cmd_thrsel = cmd_loss_threshold;
            nxt_cmd_inv = cmd_clk_invert;
            nxt_cmd_e3 = cmd_rate_e3;
            nxt_cmd_sts1 = cmd_rate_sts1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_eqdis_ff <= `LPD_CMD_EQDIS_DEF;
            cmd_lloop_ff <= `LPD_CMD_LLOOP_DEF;
            cmd_rloop_ff <= `LPD_CMD_RLOOP_DEF;
            cmd_thrsel_ff <= `LPD_CMD_THRSEL_DEF;
            cmd_inv_ff <= `LPD_CMD_INV_DEF;
            cmd_e3_ff <= `LPD_CMD_E3_DEF;
            cmd_sts1_ff <= `LPD_CMD_STS1_DEF;
        end
        else
        begin
            cmd_eqdis_ff <= nxt_cmd_eqdis;
            cmd_lloop_ff <= nxt_cmd_lloop;
            cmd_rloop_ff <= nxt_cmd_rloop;
            cmd_thrsel_ff <= nxt_cmd_thrsel;
            cmd_inv_ff <= nxt_cmd_inv;
            cmd_e3_ff <= nxt_cmd_e3;
            cmd_sts1_ff <= nxt_cmd_sts1;
        end
    end

    // ****************************************************************
    // mode selection
    // ****************************************************************
    logic sel_eqdis, sel_lloop, sel_rloop, sel_inv, sel_e3;

    always_comb
    begin
        if (is_host)
        begin
            sel_eqdis = cmd_eqdis_ff;
            sel_lloop = cmd_lloop_ff;
            sel_rloop = cmd_rloop_ff;
            sel_inv = cmd_inv_ff;
            sel_e3 = cmd_e3_ff;
        end
        else
        begin
            // shared pin is the clock invert select in hardware mode
            sel_eqdis = pin_s[`LPD_PIN_EQDIS];
            sel_lloop = pin_s[`LPD_PIN_LLOOP];
            sel_rloop = pin_s[`LPD_PIN_RLOOP];
            sel_inv = pin_s[`LPD_PIN_REGRST];
            sel_e3 = pin_s[`LPD_PIN_E3];
        end
    end

    // ****************************************************************
    // decoded configuration registers
    // ****************************************************************
    logic host_ff, eq_en_ff, thr_hi_ff, thr_act_ff;
    logic ana_ff, dig_ff, rem_ff;
    logic nxt_host, nxt_eq_en, nxt_thr_hi, nxt_thr_act;
    logic nxt_ana, nxt_dig, nxt_rem;
    lpd_pkg::lpd_loop_t loop_ff;
    lpd_pkg::lpd_loop_t nxt_loop;

    always_comb
    begin
        nxt_host = is_host;
        nxt_eq_en = !sel_eqdis;
        // threshold pin stays live in both modes; only the rate gates it
        nxt_thr_act = !sel_e3;
        nxt_thr_hi = nxt_thr_act && pin_s[`LPD_PIN_THRSEL];
        unique case ({sel_lloop, sel_rloop})
            2'h2: nxt_loop = lpd_pkg::LPD_LOOP_ANALOG_LOCAL;
            2'h3: nxt_loop = lpd_pkg::LPD_LOOP_DIGITAL_LOCAL;
            2'h1: nxt_loop = lpd_pkg::LPD_LOOP_REMOTE;
            2'h0: nxt_loop = lpd_pkg::LPD_LOOP_NONE;
        endcase
        nxt_ana = (nxt_loop == lpd_pkg::LPD_LOOP_ANALOG_LOCAL);
        nxt_dig = (nxt_loop == lpd_pkg::LPD_LOOP_DIGITAL_LOCAL);
        nxt_rem = (nxt_loop == lpd_pkg::LPD_LOOP_REMOTE);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_ff <= `LPD_BIT_LOW;
            eq_en_ff <= `LPD_BIT_HIGH;
            thr_hi_ff <= `LPD_BIT_LOW;
            thr_act_ff <= `LPD_BIT_HIGH;
            loop_ff <= lpd_pkg::LPD_LOOP_NONE;
            ana_ff <= `LPD_BIT_LOW;
            dig_ff <= `LPD_BIT_LOW;
            rem_ff <= `LPD_BIT_LOW;
        end
        else
        begin
            host_ff <= nxt_host;
            eq_en_ff <= nxt_eq_en;
            thr_hi_ff <= nxt_thr_hi;
            thr_act_ff <= nxt_thr_act;
            loop_ff <= nxt_loop;
            ana_ff <= nxt_ana;
            dig_ff <= nxt_dig;
            rem_ff <= nxt_rem;
        end
    end

    // ****************************************************************
    // recovered clock and rail data launch
    // ****************************************************************
    // clock is mclk divided by two so both edges are visible to mclk logic
    logic rclk_ff, pos_ff, neg_ff;
    logic nxt_rclk, nxt_pos, nxt_neg;
    logic launch;

    always_comb
    begin
        nxt_rclk = !rclk_ff;
        // invert low: launch as clock rises; high: as it falls
        launch = sel_inv ? !nxt_rclk : nxt_rclk;
        nxt_pos = launch ? rx_pos_in : pos_ff;
        nxt_neg = launch ? rx_neg_in : neg_ff;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rclk_ff <= `LPD_BIT_LOW;
            pos_ff <= `LPD_BIT_LOW;
            neg_ff <= `LPD_BIT_LOW;
        end
        else
        begin
            rclk_ff <= nxt_rclk;
            pos_ff <= nxt_pos;
            neg_ff <= nxt_neg;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rx_recovered_clk_b = rclk_ff;
    assign rx_pos_rail_data = pos_ff;
    assign rx_neg_rail_data = neg_ff;
    assign host_mode = host_ff;
    assign equalizer_enable = eq_en_ff;
    assign loss_threshold_high = thr_hi_ff;
    assign loss_threshold_active = thr_act_ff;
    assign loop_mode = loop_ff;
    assign analog_local_loop = ana_ff;
    assign digital_local_loop = dig_ff;
    assign remote_loop = rem_ff;

endmodule // lpd_top

// ### dv/lpd_top_properties.sv
`timescale 1ns/100ps
// ****
// pin decode checks
// ****
module lpd_chk (
    // clock, reset and pins
    input wire logic mclk, rst_n, host_hardware_mode_sel, cfg_reg_reset_n, cfg_reg_reset_drv,
    input wire logic rx_equalizer_disable, signal_loss_threshold_sel, local_loop_sel, remote_loop_sel,
    input wire logic rate_e3_sel, cmd_wr,
    // outputs
    input wire logic rx_recovered_clk_b, rx_pos_rail_data, host_mode, equalizer_enable,
    input wire logic loss_threshold_high, loss_threshold_active,
    input wire lpd_pkg::lpd_loop_t loop_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire hw = !host_hardware_mode_sel;
    // undriven pin reads high
    wire inv_hi = !cfg_reg_reset_drv || cfg_reg_reset_n;
    lpd_pkg::lpd_loop_t exp_loop;
    assign exp_loop = local_loop_sel ? (remote_loop_sel ? lpd_pkg::LPD_LOOP_DIGITAL_LOCAL
        : lpd_pkg::LPD_LOOP_ANALOG_LOCAL) : (remote_loop_sel ? lpd_pkg::LPD_LOOP_REMOTE : lpd_pkg::LPD_LOOP_NONE);
    property p_reg_rst;
        (host_hardware_mode_sel && !inv_hi)[*6] |-> equalizer_enable && loop_mode == lpd_pkg::LPD_LOOP_NONE;
    endproperty
    a_reg_rst: assert property (p_reg_rst) else $error("reg reset kept settings");
    property p_rise;
        (hw && !inv_hi)[*5] ##0 $changed(rx_pos_rail_data) |-> $rose(rx_recovered_clk_b);
    endproperty
    a_rise: assert property (p_rise) else $error("data not on rising edge");
    property p_fall;
        (hw && inv_hi)[*5] ##0 $changed(rx_pos_rail_data) |-> $fell(rx_recovered_clk_b);
    endproperty
    a_fall: assert property (p_fall) else $error("data not on falling edge");
    property p_eq;
        (hw && $stable(rx_equalizer_disable))[*4] |-> equalizer_enable == !rx_equalizer_disable;
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer wrong");
    property p_host;
        (host_hardware_mode_sel && !cmd_wr && inv_hi)[*6] |-> $stable(equalizer_enable) && $stable(loop_mode);
    endproperty
    a_host: assert property (p_host) else $error("host settings moved");
    property p_thr;
        (hw && !rate_e3_sel && $stable(signal_loss_threshold_sel))[*4]
            |-> loss_threshold_active && loss_threshold_high == signal_loss_threshold_sel;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold wrong");
    property p_e3;
        (hw && rate_e3_sel)[*4] |-> !loss_threshold_active && !loss_threshold_high;
    endproperty
    a_e3: assert property (p_e3) else $error("threshold used at e3");
    property p_loop;
        (hw && $stable(local_loop_sel) && $stable(remote_loop_sel))[*4] |-> !host_mode && loop_mode == exp_loop;
    endproperty
    a_loop: assert property (p_loop) else $error("loop decode wrong");
endmodule // lpd_chk

bind lpd_top lpd_chk u_lpd_chk (.*);

// ### dv/lpd_board.sv
`timescale 1ns/100ps
// ****
// board strapping
// ****
module lpd_board (
    // wanted levels
    input wire logic mclk, w_host, w_eqdis, w_thr, w_lloop, w_rloop, w_e3, w_pin, w_drv,
    // strapped pins
    output logic host_hardware_mode_sel, cfg_reg_reset_n, cfg_reg_reset_drv, rx_equalizer_disable,
    output logic signal_loss_threshold_sel, local_loop_sel, remote_loop_sel, rate_e3_sel, rate_sts1_sel
);
    logic last_ff;
    always_ff @(posedge mclk)
    begin
        if (w_drv)
            last_ff <= w_pin;
    end
    always_comb
    begin
        host_hardware_mode_sel = w_host;
        cfg_reg_reset_drv = w_drv;
        // released pin shows no stale level
        cfg_reg_reset_n = w_drv ? w_pin : !last_ff;
        rx_equalizer_disable = w_eqdis && !w_host;
        local_loop_sel = w_lloop && !w_host;
        remote_loop_sel = w_rloop && !w_host;
        rate_e3_sel = w_e3 && !w_host;
        signal_loss_threshold_sel = w_thr;
        rate_sts1_sel = 1'h0;
    end
endmodule // lpd_board

// ### dv/tb.sv
`timescale 1ns/100ps
// ****
// bench
// ****
module tb;
    logic mclk, rst_n, w_host, w_eqdis, w_thr, w_lloop, w_rloop, w_e3, w_pin, w_drv;
    logic host_hardware_mode_sel, cfg_reg_reset_n, cfg_reg_reset_drv, rx_equalizer_disable;
    logic signal_loss_threshold_sel, local_loop_sel, remote_loop_sel, rate_e3_sel, rate_sts1_sel;
    logic cmd_wr, cmd_eq_disable, cmd_local_loop, cmd_remote_loop, cmd_loss_threshold, cmd_clk_invert;
    logic cmd_rate_e3, cmd_rate_sts1, rx_pos_in, rx_neg_in, rx_recovered_clk_b, rx_pos_rail_data;
    logic rx_neg_rail_data, host_mode, equalizer_enable, loss_threshold_high, loss_threshold_active;
    logic analog_local_loop, digital_local_loop, remote_loop;
    lpd_pkg::lpd_loop_t loop_mode;
    lpd_pkg::lpd_loop_t lp [4] = '{lpd_pkg::LPD_LOOP_NONE, lpd_pkg::LPD_LOOP_REMOTE,
        lpd_pkg::LPD_LOOP_ANALOG_LOCAL, lpd_pkg::LPD_LOOP_DIGITAL_LOCAL};
    logic [2:0] fl [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
    int errors, num_checks, n;
    lpd_top u_lpd_top (.*);
    lpd_board u_lpd_board (.*);
    assign rx_neg_in = !rx_pos_in;
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = !mclk;
    end
    task chk(string nm, logic [2:0] seen, logic [2:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // 2 sync stages, command register and output register, one spare
    task pins(logic [7:0] v);
        {w_host, w_eqdis, w_thr, w_lloop, w_rloop, w_e3, w_pin, w_drv} = v;
        cyc(5);
    endtask
    task cmd(logic [6:0] v);
        {cmd_eq_disable, cmd_local_loop, cmd_remote_loop, cmd_loss_threshold, cmd_clk_invert, cmd_rate_e3,
            cmd_rate_sts1} = v;
        cmd_wr = 1'h1;
        cyc(1);
        cmd_wr = 1'h0;
        cyc(3);
    endtask
    // input changes every 2 cycles so each launch sees new data
    task rail(logic lvl);
        logic prv;
        int c;
        c = 0;
        prv = rx_pos_rail_data;
        for (int i = 0; i < 8; i++)
        begin
            if (!i[0])
                rx_pos_in = !rx_pos_in;
            cyc(1);
            if (rx_pos_rail_data !== prv)
            begin
                c++;
                chk("clk_b at launch", rx_recovered_clk_b, lvl);
                chk("neg rail", rx_neg_rail_data, !rx_pos_rail_data);
            end
            prv = rx_pos_rail_data;
        end
        chk("launches", c[2:0], 3'h4);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        errors = 0;
        num_checks = 0;
        rst_n = 1'h0;
        cmd_wr = 1'h0;
        rx_pos_in = 1'h0;
        {w_host, w_eqdis, w_thr, w_lloop, w_rloop, w_e3, w_pin, w_drv} = 8'h03;
        {cmd_eq_disable, cmd_local_loop, cmd_remote_loop, cmd_loss_threshold, cmd_clk_invert, cmd_rate_e3,
            cmd_rate_sts1} = 7'h00;
        cyc(20);
        rst_n = 1'h1;
        cyc(5);
        chk("host_mode", host_mode, 3'h0);
        $display("reset test done");
        for (n = 0; n < 4; n++)
        begin
            pins({3'h0, n[1], n[0], 3'h3});
            chk("loop_mode", loop_mode, lp[n]);
            chk("loop flags", {analog_local_loop, digital_local_loop, remote_loop}, fl[n]);
            pins({1'h0, n[0], n[1], 5'h03});
            chk("eq enable", equalizer_enable, !n[0]);
            chk("thr", {loss_threshold_active, loss_threshold_high}, {2'h2 | n[1]});
        end
        pins(8'h27);
        chk("thr e3", {loss_threshold_active, loss_threshold_high}, 3'h0);
        $display("hardware decode test done");
        pins(8'h01);
        rail(1'h1);
        pins(8'h03);
        rail(1'h0);
        $display("rail edge test done");
        pins(8'hdf);
        cmd(7'h60);
        chk("host eq", equalizer_enable, 3'h0);
        chk("host loop", loop_mode, lpd_pkg::LPD_LOOP_ANALOG_LOCAL);
        pins(8'h81);
        chk("reg reset eq", equalizer_enable, 3'h1);
        chk("reg reset loop", loop_mode, lpd_pkg::LPD_LOOP_NONE);
        pins(8'h83);
        cmd(7'h40);
        pins(8'h80);
        chk("undriven reset", equalizer_enable, 3'h0);
        pins(8'ha0);
        chk("host thr", {loss_threshold_active, loss_threshold_high}, 3'h3);
        cmd(7'h06);
        chk("host thr e3", {loss_threshold_active, loss_threshold_high}, 3'h0);
        rail(1'h0);
        $display("host test done");
        close_out();
    end
endmodule // tb
